//--- lsc_regs.vh
// Register map, field positions, reset values and timing for line state control
`ifndef LSC_REGS_VH
`define LSC_REGS_VH

// Register index within a channel window, byte address = chan*0x20 + idx*4
`define LSC_IDX_LINE      3'h0
`define LSC_IDX_OCV       3'h1
`define LSC_IDX_LOOP_CURRENT_LIMIT      3'h2
`define LSC_IDX_CMO       3'h3
`define LSC_IDX_BOV       3'h4
`define LSC_IDX_CFG       3'h5
`define LSC_CHAN_BIT      5

// LINE register fields
`define LSC_LINE_SEL_LSB  0
`define LSC_LINE_ACT_LSB  4
`define LSC_LINE_FLT_BIT  8
`define LSC_LINE_HOOK_BIT 9
`define LSC_LINE_STBY_BIT 10
`define LSC_LINE_CAL_BIT  11

// CFG register fields
`define LSC_CFG_IMP_BIT   0
`define LSC_CFG_EXT_BIT   1
`define LSC_CFG_CAL_BIT   2

// Line state codes
`define LSC_ST_OPEN       3'h0
`define LSC_ST_FWD_ACT    3'h1
`define LSC_ST_FWD_OHT    3'h2
`define LSC_ST_TIP_OPEN   3'h3
`define LSC_ST_RINGING    3'h4
`define LSC_ST_REV_ACT    3'h5
`define LSC_ST_REV_OHT    3'h6
`define LSC_ST_RING_OPEN  3'h7

// Reset values, voltage LSB 4.907 mV
`define LSC_RST_OCV       15'h0000
`define LSC_RST_LOOP_CURRENT_LIMIT      5'h00
`define LSC_RST_CMO       15'h0266
`define LSC_RST_BOV       15'h0333
`define LSC_RST_CFG       2'h0

// Calibration timing
`define LSC_CLK_MHZ       25
`define LSC_CAL_TIME_US   100
// 100 us at 25 MHz, sized to the cycle counter
`define LSC_CAL_CYC       12'h9C4

`endif

//--- lsc_sync.v
// Two flip-flop synchroniser for asynchronous pins
`timescale 1ns/100ps
module lsc_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         sys_rst,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

reg [W-1:0] meta_q;
reg [W-1:0] sync_q;

always @(posedge clk) begin
    if (sys_rst) begin
        meta_q <= {W{1'b0}};
        sync_q <= {W{1'b0}};
    end else begin
        meta_q <= async_in;
        sync_q <= meta_q;
    end
end

assign sync_out = sync_q;

endmodule // lsc_sync

//--- lsc_line_ctrl.v
// Dual channel line state control with APB register access
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "lsc_regs.vh"

// Notes on behaviour
// - Eight line states per channel, picked by a three-bit software field.
// - After reset the line state is open, code 000.
// - Excess driver power forces the channel open without software action.
// - Code 000 puts both driver outputs in high impedance.
// - Code 001 feeds forward; audio stays off until off-hook.
// - Active states drop to low-power standby while on-hook.
// - Code 010 keeps transmit path up with loop on-hook.
// - Code 011 floats TIP driver and feeds RING.
// - Code 100 rings internally, or drives external ring relay.
// - Code 101 feeds reversed; audio stays off until off-hook.
// - Code 110 transmits on-hook in reversed polarity.
// - Open-circuit voltage programmable up to 63.3 V.
// - Loop current limit programmable 18 to 45 mA in steps.
// - Active feed impedance is 640 or 320 ohms.
// - Programmable common-mode offset below ground for positive terminal.
// - Programmable overhead between negative terminal and battery rail.
// - Common-mode offset resets to the 3 V code.
// - Sensing circuitry calibrates itself on-chip.
// - Code 111 floats RING driver and feeds TIP.
module lsc_line_ctrl (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output wire [31:0] prdata,
    input  wire [1:0]  pwr_excess,
    input  wire [1:0]  off_hook,
    output wire [1:0]  tip_drive_en,
    output wire [1:0]  ring_drive_en,
    output wire [1:0]  polarity_rev,
    output wire [1:0]  audio_pwr_en,
    output wire [1:0]  tx_onhook_en,
    output wire [1:0]  standby_mode,
    output wire [1:0]  ring_gen_en,
    output wire [1:0]  ring_relay_on,
    output wire [1:0]  feed_imp_320,
    output wire [29:0] open_circuit_voltage,
    output wire [9:0]  loop_current_limit,
    output wire [29:0] common_mode_offset,
    output wire [29:0] battery_overhead_voltage,
    output wire        cal_active
);

localparam [11:0] CAL_CYC = `LSC_CAL_CYC;

// Synchronised pins
wire [3:0] pin_s;
wire [1:0] fault_s;
wire [1:0] hook_s;

lsc_sync #(
    .W(4)
) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({off_hook, pwr_excess}),
    .sync_out (pin_s)
);

assign fault_s = pin_s[1:0];
assign hook_s  = pin_s[3:2];

// Per-channel storage
reg [2:0]  sel_q  [0:1];
reg [2:0]  act_q  [0:1];
reg        flt_q  [0:1];
reg [14:0] ocv_q  [0:1];
reg [4:0]  loop_current_limit_q [0:1];
reg [14:0] cmo_q  [0:1];
reg [14:0] bov_q  [0:1];
reg [1:0]  cfg_q  [0:1];

// Bus decode
wire       chan;
wire [2:0] idx;
wire       hit;
wire       acc;
wire       wr_en;
wire [1:0] wr_ch;

assign chan  = paddr[`LSC_CHAN_BIT];
assign idx   = paddr[4:2];
assign hit   = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) &&
               (idx <= `LSC_IDX_CFG);
assign acc   = psel & penable;
assign wr_en = acc & pwrite & hit;
assign wr_ch = {wr_en & chan, wr_en & ~chan};

assign pready  = 1'b1;
assign pslverr = acc & ~hit;

// Calibration engine
reg [11:0] cal_cnt_q;
reg        cal_busy_q;
wire       cal_start;

assign cal_start = wr_en && (idx == `LSC_IDX_CFG) &&
                   pwdata[`LSC_CFG_CAL_BIT];

always @(posedge clk) begin
    if (sys_rst) begin
        cal_busy_q <= 1'b1;
        cal_cnt_q  <= 12'h000;
    end else if (cal_start) begin
        cal_busy_q <= 1'b1;
        cal_cnt_q  <= 12'h000;
    end else if (cal_busy_q) begin
        if (cal_cnt_q == CAL_CYC - 12'h001) begin
            cal_busy_q <= 1'b0;
        end
        cal_cnt_q <= cal_cnt_q + 12'h001;
    end
end

assign cal_active = cal_busy_q;

// Register writes and fault handling
integer i;

always @(posedge clk) begin
    for (i = 0; i < 2; i = i + 1) begin
        if (sys_rst) begin
            sel_q[i]  <= `LSC_ST_OPEN;
            act_q[i]  <= `LSC_ST_OPEN;
            flt_q[i]  <= 1'b0;
            ocv_q[i]  <= `LSC_RST_OCV;
            loop_current_limit_q[i] <= `LSC_RST_LOOP_CURRENT_LIMIT;
            cmo_q[i]  <= `LSC_RST_CMO;
            bov_q[i]  <= `LSC_RST_BOV;
            cfg_q[i]  <= `LSC_RST_CFG;
        end else begin
            if (fault_s[i]) begin
                sel_q[i] <= `LSC_ST_OPEN;
            end else if (wr_ch[i] && idx == `LSC_IDX_LINE) begin
                sel_q[i] <= pwdata[2:0];
            end
            act_q[i] <= sel_q[i];
            if (fault_s[i]) begin
                flt_q[i] <= 1'b1;
            end else if (wr_ch[i] && idx == `LSC_IDX_LINE &&
                         pwdata[`LSC_LINE_FLT_BIT]) begin
                flt_q[i] <= 1'b0;
            end
            if (wr_ch[i] && idx == `LSC_IDX_OCV) begin
                ocv_q[i] <= pwdata[14:0];
            end
            if (wr_ch[i] && idx == `LSC_IDX_LOOP_CURRENT_LIMIT) begin
                loop_current_limit_q[i] <= pwdata[4:0];
            end
            if (wr_ch[i] && idx == `LSC_IDX_CMO) begin
                cmo_q[i] <= pwdata[14:0];
            end
            if (wr_ch[i] && idx == `LSC_IDX_BOV) begin
                bov_q[i] <= pwdata[14:0];
            end
            if (wr_ch[i] && idx == `LSC_IDX_CFG) begin
                cfg_q[i] <= pwdata[1:0];
            end
        end
    end
end

// Driver control per channel
reg [1:0] tip_q;
reg [1:0] ring_q;
reg [1:0] rev_q;
reg [1:0] aud_q;
reg [1:0] oht_q;
reg [1:0] stby_q;
reg [1:0] rgen_q;
reg [1:0] rly_q;
reg [1:0] imp_q;
reg [1:0] act_on;

integer k;

always @(posedge clk) begin
    for (k = 0; k < 2; k = k + 1) begin
        if (sys_rst) begin
            tip_q[k]  <= 1'b0;
            ring_q[k] <= 1'b0;
            rev_q[k]  <= 1'b0;
            aud_q[k]  <= 1'b0;
            oht_q[k]  <= 1'b0;
            stby_q[k] <= 1'b0;
            rgen_q[k] <= 1'b0;
            rly_q[k]  <= 1'b0;
            imp_q[k]  <= 1'b0;
            act_on[k] <= 1'b0;
        end else begin
            tip_q[k]  <= 1'b0;
            ring_q[k] <= 1'b0;
            rev_q[k]  <= 1'b0;
            aud_q[k]  <= 1'b0;
            oht_q[k]  <= 1'b0;
            stby_q[k] <= 1'b0;
            rgen_q[k] <= 1'b0;
            rly_q[k]  <= 1'b0;
            act_on[k] <= 1'b0;
            imp_q[k]  <= 1'b0;
            case (act_q[k])
                `LSC_ST_OPEN: begin
                    tip_q[k]  <= 1'b0;
                    ring_q[k] <= 1'b0;
                end
                `LSC_ST_FWD_ACT: begin
                    tip_q[k]  <= 1'b1;
                    ring_q[k] <= 1'b1;
                    act_on[k] <= 1'b1;
                    aud_q[k]  <= hook_s[k];
                    stby_q[k] <= ~hook_s[k];
                    imp_q[k]  <= cfg_q[k][`LSC_CFG_IMP_BIT];
                end
                `LSC_ST_FWD_OHT: begin
                    tip_q[k]  <= 1'b1;
                    ring_q[k] <= 1'b1;
                    aud_q[k]  <= 1'b1;
                    oht_q[k]  <= 1'b1;
                end
                `LSC_ST_TIP_OPEN: begin
                    tip_q[k]  <= 1'b0;
                    ring_q[k] <= 1'b1;
                end
                `LSC_ST_RINGING: begin
                    if (cfg_q[k][`LSC_CFG_EXT_BIT]) begin
                        rly_q[k] <= 1'b1;
                    end else begin
                        tip_q[k]  <= 1'b1;
                        ring_q[k] <= 1'b1;
                        rgen_q[k] <= 1'b1;
                    end
                end
                `LSC_ST_REV_ACT: begin
                    tip_q[k]  <= 1'b1;
                    ring_q[k] <= 1'b1;
                    rev_q[k]  <= 1'b1;
                    act_on[k] <= 1'b1;
                    aud_q[k]  <= hook_s[k];
                    stby_q[k] <= ~hook_s[k];
                    imp_q[k]  <= cfg_q[k][`LSC_CFG_IMP_BIT];
                end
                `LSC_ST_REV_OHT: begin
                    tip_q[k]  <= 1'b1;
                    ring_q[k] <= 1'b1;
                    rev_q[k]  <= 1'b1;
                    aud_q[k]  <= 1'b1;
                    oht_q[k]  <= 1'b1;
                end
                `LSC_ST_RING_OPEN: begin
                    tip_q[k]  <= 1'b1;
                    ring_q[k] <= 1'b0;
                end
                default: begin
                    tip_q[k]  <= 1'b0;
                    ring_q[k] <= 1'b0;
                end
            endcase
        end
    end
end

assign tip_drive_en  = tip_q;
assign ring_drive_en = ring_q;
assign polarity_rev  = rev_q;
assign audio_pwr_en  = aud_q;
assign tx_onhook_en  = oht_q;
assign standby_mode  = stby_q;
assign ring_gen_en   = rgen_q;
assign ring_relay_on = rly_q;
assign feed_imp_320  = imp_q;

// Feed parameters to the analog loop
assign open_circuit_voltage     = {ocv_q[1], ocv_q[0]};
assign loop_current_limit       = {loop_current_limit_q[1], loop_current_limit_q[0]};
assign common_mode_offset       = {cmo_q[1], cmo_q[0]};
assign battery_overhead_voltage = {bov_q[1], bov_q[0]};

// Read path, captured in the setup cycle
reg [31:0] rdata_d;
reg [31:0] rdata_q;

always @* begin
    rdata_d = 32'h00000000;
    case (idx)
        `LSC_IDX_LINE: begin
            rdata_d[2:0] = sel_q[chan];
            rdata_d[6:4] = act_q[chan];
            rdata_d[`LSC_LINE_FLT_BIT]  = flt_q[chan];
            rdata_d[`LSC_LINE_HOOK_BIT] = hook_s[chan];
            rdata_d[`LSC_LINE_STBY_BIT] = stby_q[chan];
            rdata_d[`LSC_LINE_CAL_BIT]  = ~cal_busy_q;
        end
        `LSC_IDX_OCV:  rdata_d[14:0] = ocv_q[chan];
        `LSC_IDX_LOOP_CURRENT_LIMIT: rdata_d[4:0]  = loop_current_limit_q[chan];
        `LSC_IDX_CMO:  rdata_d[14:0] = cmo_q[chan];
        `LSC_IDX_BOV:  rdata_d[14:0] = bov_q[chan];
        `LSC_IDX_CFG:  rdata_d[1:0]  = cfg_q[chan];
        default:       rdata_d = 32'h00000000;
    endcase
    if (!hit) begin
        rdata_d = 32'h00000000;
    end
end

always @(posedge clk) begin
    if (sys_rst) begin
        rdata_q <= 32'h00000000;
    end else if (psel && !penable) begin
        rdata_q <= rdata_d;
    end
end

assign prdata = rdata_q;

endmodule // lsc_line_ctrl

//--- lsc_line_chk_sva.sv
// Checker for line state control driver outputs
`timescale 1ns/100ps
module lsc_line_chk (
    input wire        clk,
    input wire        sys_rst,
    input wire [1:0]  pwr_excess,
    input wire [1:0]  tip_drive_en,
    input wire [1:0]  ring_drive_en,
    input wire [1:0]  polarity_rev,
    input wire [1:0]  audio_pwr_en,
    input wire [1:0]  tx_onhook_en,
    input wire [1:0]  standby_mode,
    input wire [1:0]  ring_gen_en,
    input wire [1:0]  ring_relay_on,
    input wire [29:0] common_mode_offset,
    input wire        cal_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    reset_vals_a: assert property ($fell(sys_rst) |-> cal_active &&
        common_mode_offset == {2{15'h0266}} && tip_drive_en == 2'h0)
        else $error("bad values after reset");
    fault_open_a: assert property ($rose(pwr_excess[0]) |->
        ##[1:8] (tip_drive_en[0] == 1'b0 && ring_drive_en[0] == 1'b0))
        else $error("fault did not open the line");
    rev_feed_a: assert property (
        (polarity_rev & ~(tip_drive_en & ring_drive_en)) == 2'h0)
        else $error("reversed without both sides fed");
    relay_off_a: assert property (ring_relay_on[0] |->
        !tip_drive_en[0] && !ring_drive_en[0] && !ring_gen_en[0])
        else $error("relay ringing with drivers on");
    ring_gen_a: assert property (ring_gen_en[0] |->
        tip_drive_en[0] && ring_drive_en[0] && !audio_pwr_en[0])
        else $error("internal ringing without feed");
    standby_a: assert property (standby_mode[0] |->
        tip_drive_en[0] && ring_drive_en[0] && !audio_pwr_en[0])
        else $error("standby with audio or no feed");
    onhook_tx_a: assert property (tx_onhook_en[0] |->
        audio_pwr_en[0] && !standby_mode[0] && ring_drive_en[0])
        else $error("on-hook transmit without audio");
    half_open_a: assert property (
        tip_drive_en[0] != ring_drive_en[0] |->
        !polarity_rev[0] && !standby_mode[0] && !ring_gen_en[0])
        else $error("single side feed in wrong mode");

    cover property (standby_mode[0]);
    cover property (ring_relay_on[0]);
    cover property ($rose(pwr_excess[0]));
endmodule // lsc_line_chk

bind lsc_line_ctrl lsc_line_chk lsc_line_chk_inst (.*);

//--- lsc_loop_model.sv
// Line driver and subscriber loop model
`timescale 1ns/100ps
module lsc_loop_model (
    input  wire       clk,
    input  wire [1:0] tip_drive_en,
    input  wire [1:0] ring_drive_en,
    input  wire [1:0] hook_req,
    input  wire [1:0] overload_req,
    output reg  [1:0] off_hook = 2'h0,
    output reg  [1:0] pwr_excess = 2'h0
);
    // Loop current and driver heat exist only while a side is fed
    always @(posedge clk) begin
        off_hook <= hook_req & (tip_drive_en | ring_drive_en);
        pwr_excess <= overload_req & (tip_drive_en | ring_drive_en);
    end
endmodule // lsc_loop_model

//--- lsc_line_ctrl_tb.sv
// Testbench for dual channel line state control
`timescale 1ns/100ps
module lsc_line_ctrl_tb;
    reg         clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0;
    reg  [1:0]  hook_req = 2'h0;
    reg  [1:0]  overload_req = 2'h0;
    reg         snap = 1'b0;
    // Chooses which output word a snapshot compares
    reg  [2:0]  fsel = 3'h0;
    reg  [29:0] fx[0:3];
    reg  [31:0] r;
    reg  [32:0] q[$];
    wire        pready, pslverr, cal_active;
    wire [31:0] prdata;
    wire [9:0]  loop_current_limit;
    wire [29:0] open_circuit_voltage, common_mode_offset;
    wire [29:0] battery_overhead_voltage;
    wire [1:0]  tip_drive_en, ring_drive_en, polarity_rev, audio_pwr_en;
    wire [1:0]  tx_onhook_en, standby_mode, ring_gen_en, ring_relay_on;
    wire [1:0]  feed_imp_320, off_hook, pwr_excess;
    wire [8:0]  pv = {tip_drive_en[0], ring_drive_en[0], polarity_rev[0],
        audio_pwr_en[0], tx_onhook_en[0], standby_mode[0], ring_gen_en[0],
        ring_relay_on[0], feed_imp_320[0]};
    wire [8:0]  pv1 = {tip_drive_en[1], ring_drive_en[1], polarity_rev[1],
        audio_pwr_en[1], tx_onhook_en[1], standby_mode[1], ring_gen_en[1],
        ring_relay_on[1], feed_imp_320[1]};
    wire [32:0] fv = fsel == 3'h1 ? {3'h0, open_circuit_voltage} :
        fsel == 3'h2 ? {23'h0, loop_current_limit} :
        fsel == 3'h3 ? {3'h0, common_mode_offset} :
        fsel == 3'h4 ? {3'h0, battery_overhead_voltage} :
        fsel == 3'h5 ? {24'h0, pv1} : {24'h0, pv};
    localparam [71:0] EPK = {9'h100, 9'h1F0, 9'h1C8, 9'h184,
                             9'h080, 9'h1B0, 9'h188, 9'h000};
    integer     seed = 32'hbc891be2;
    integer     n_errors = 0;
    integer     checked = 0;
    integer     s, i, c, n;

    lsc_line_ctrl lsc_line_ctrl_inst (.*);
    lsc_loop_model lsc_loop_model_inst (.*);

    initial forever #20 clk = ~clk;

    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checked, n_errors);
            if (n_errors == 0 && checked > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    task chk(input [32:0] seen, input [32:0] exp, input pin);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %s exp %h seen %h",
                    pin ? "pins" : "prdata", exp, seen);
            end
        end
    endtask

    // Oldest expectation meets each read answer or pin snapshot
    always @(posedge clk)
        if (snap || (psel && penable && !pwrite && pready))
            chk(snap ? fv : {pslverr, prdata}, q.pop_front(), snap);

    task apb(input w, input [7:0] a, input [31:0] d, input [32:0] e);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            if (!w) q.push_back(e);
            n = 0;
            @(posedge clk);
            while (pready !== 1'b1) begin
                n = n + 1;
                if (n > 50) begin
                    n_errors = n_errors + 1;
                    tally_and_finish;
                end
                @(posedge clk);
            end
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task feed(input [2:0] k, input [32:0] e);
        begin
            q.push_back(e);
            fsel <= k;
            snap <= 1'b1;
            @(posedge clk);
            snap <= 1'b0;
        end
    endtask

    task pins(input [8:0] e);
        begin
            feed(3'h0, {24'h0, e});
        end
    endtask

    task line(input [2:0] st);
        begin
            r = $random(seed);
            apb(1'b1, 8'h00, {r[31:3], st}, 33'h0);
            repeat (4) @(posedge clk);
        end
    endtask

    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        pins(9'h000);
        apb(1'b0, 8'h00, 0, 33'h0);
        apb(1'b0, 8'h0C, 0, 33'h266);
        apb(1'b0, 8'h2C, 0, 33'h266);
        apb(1'b0, 8'h10, 0, 33'h333);
        apb(1'b0, 8'h18, 0, {1'b1, 32'h0});
        apb(1'b0, 8'h41, 0, {1'b1, 32'h0});
        n = 0;
        while (cal_active !== 1'b0) begin
            n = n + 1;
            if (n > 3000) begin
                n_errors = n_errors + 1;
                tally_and_finish;
            end
            @(posedge clk);
        end
        $display("done: reset");
        for (s = 0; s < 8; s = s + 1) begin
            line(s[2:0]);
            pins(EPK[s*9 +: 9]);
            apb(1'b0, 8'h00, 0, {22'h1, EPK[s*9+3], 3'h0, s[2:0],
                1'b0, s[2:0]});
        end
        $display("done: states");
        line(3'h1);
        hook_req <= 2'h1;
        repeat (6) @(posedge clk);
        pins(9'h1A0);
        apb(1'b0, 8'h00, 0, 33'hA11);
        hook_req <= 2'h0;
        apb(1'b1, 8'h14, 32'h3, 33'h0);
        apb(1'b0, 8'h14, 0, 33'h3);
        line(3'h4);
        pins(9'h002);
        line(3'h5);
        pins(9'h1C9);
        apb(1'b1, 8'h14, 32'h0, 33'h0);
        $display("done: hook and config");
        line(3'h1);
        overload_req <= 2'h1;
        repeat (8) @(posedge clk);
        pins(9'h000);
        apb(1'b0, 8'h00, 0, 33'h900);
        overload_req <= 2'h0;
        apb(1'b1, 8'h00, 32'h101, 33'h0);
        repeat (4) @(posedge clk);
        apb(1'b0, 8'h00, 0, 33'hC11);
        $display("done: fault");
        for (c = 0; c < 64; c = c + 32)
            for (i = 4; i < 20; i = i + 4) begin
                r = $random(seed);
                apb(1'b1, 8'(c + i), r, 33'h0);
                apb(1'b0, 8'(c + i), 0,
                    {1'b0, r & (i == 8 ? 32'h1F : 32'h7FFF)});
                if (i == 8)
                    fx[1][c/32*5 +: 5] = r[4:0];
                else
                    fx[i/4-1][c/32*15 +: 15] = r[14:0];
            end
        feed(3'h1, {3'h0, fx[0]});
        feed(3'h2, {23'h0, fx[1][9:0]});
        feed(3'h3, {3'h0, fx[2]});
        feed(3'h4, {3'h0, fx[3]});
        apb(1'b1, 8'h20, 32'h5, 33'h0);
        repeat (4) @(posedge clk);
        apb(1'b0, 8'h20, 0, 33'hC55);
        feed(3'h5, {24'h0, 9'h1C8});
        $display("done: registers");
        tally_and_finish;
    end
endmodule // lsc_line_ctrl_tb
